// ===== shared/host_bus_byte_pkg.sv
package host_bus_byte_pkg;

    // Mode field encodings
    localparam logic [3:0] MAIN_MODE_HOST_BYTE = 4'h2;
    localparam logic [3:0] SUB_MODE_MUXED = 4'h0;

    // Chip-select arrangement encodings
    localparam logic [1:0] CSA_ALE_ONLY = 2'h0;
    localparam logic [1:0] CSA_ONE_CS = 2'h1;
    localparam logic [1:0] CSA_TWO_CS = 2'h2;
    localparam logic [1:0] CSA_ALE_TWO_CS = 2'h3;

    // Widths and field positions
    localparam int ADDR_W = 28;
    localparam int DATA_W = 8;
    localparam int UPPER_LO = 8;
    localparam int UPPER_HI = 25;
    localparam int LINE26_BIT = 26;
    localparam int CS_SEL_BIT = 27;

    // Phase times in ns and the clock rate in MHz
    localparam int CLK_MHZ = 100;
    localparam int ADDR_PHASE_NS = 20;
    localparam int GAP_PHASE_NS = 10;
    localparam int STROBE_NS = 60;
    localparam int HOLD_PHASE_NS = 10;

    // Least times round up to whole cycles
    localparam logic [3:0] ADDR_CYC =
        4'((ADDR_PHASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] GAP_CYC = 4'((GAP_PHASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] HOLD_CYC =
        4'((HOLD_PHASE_NS * CLK_MHZ + 999) / 1000);

    // Access sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_GAP = 5'b00100,
        ST_DATA = 5'b01000,
        ST_HOLD = 5'b10000
    } phase_e;

endpackage

// ===== hw/data_line_sync.sv
`timescale 1ns/1ps
`default_nettype none

module data_line_sync
    import host_bus_byte_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [DATA_W-1:0] lineIn, // Raw pin levels
    output logic [DATA_W-1:0] lineSync // Synchronised levels
);

    logic [DATA_W-1:0] stage1_reg;

    // Two flip-flops per line; the first is read only by the second
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                stage1_reg[i] <= 1'b0;
                lineSync[i] <= 1'b0;
            end else begin
                stage1_reg[i] <= lineIn[i];
                lineSync[i] <= stage1_reg[i];
            end
        end
    end

endmodule

`default_nettype wire

// ===== hw/host_bus_byte_port.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - Port works only while the main mode field holds 0x2.
// R2 - Within that mode, the sub-mode field must hold 0x0 for muxed use.
// R3 - Eight low lines carry address first, then 8-bit data.
// R4 - Sharing lines frees pins, so address reaches 28 bits; in arrangement 3 bit 26 reaches no pin.
// R5 - Latch enable pulses in the address phase; external latch holds it.
// R6 - Read strobe for reads, write strobe for writes, never both.
// R7 - Up to two peripherals; each chip select picks exactly one of them.
// R8 - Arrangement 0 latch only, 1 one select, 2 two, 3 latch plus two.
// R9 - Phases are stretched well beyond a fast single-cycle bus access.
// R10 - Muxing and select arrangement come from dedicated config inputs.
// R11 - Latch enable drops before either strobe is asserted.
module host_bus_byte_port
    import host_bus_byte_pkg::*;
(
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [3:0] interfaceMainMode, // Main mode field
    input wire logic [3:0] hostBusSubMode, // Host-bus sub-mode field
    input wire logic [1:0] chipSelectArrangement, // Select arrangement
    input wire logic reqValid, // Access request
    input wire logic reqWrite, // 1 write, 0 read
    input wire logic [ADDR_W-1:0] reqAddr, // Access address
    input wire logic [DATA_W-1:0] reqWrData, // Write data
    output logic reqReady, // Request may be taken
    output logic rspValid, // Access finished, one cycle
    output logic [DATA_W-1:0] rspRdData, // Read data
    output logic [DATA_W-1:0] adOut, // Muxed lines, driven value
    output logic [DATA_W-1:0] adOe, // Muxed lines, enable per bit
    input wire logic [DATA_W-1:0] adIn, // Muxed lines, pin level
    output logic [UPPER_HI-UPPER_LO:0] upperAddr, // Lines 8 to 25
    output logic line26, // Address 26 or select 0 (low)
    output logic line27, // Address 27 or select 1 (low)
    output logic line30, // Latch enable (high) or select 0 (low)
    output logic rdStrobeN, // Read strobe, active low
    output logic wrStrobeN // Write strobe, active low
);

    phase_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic write_reg;
    logic [1:0] arr_reg;
    logic [DATA_W-1:0] adSync;

    // Mode gate and request acceptance
    wire modeOk = (interfaceMainMode == MAIN_MODE_HOST_BYTE) // R1
        && (hostBusSubMode == SUB_MODE_MUXED); // R2
    wire take = reqValid && reqReady && (state_reg == ST_IDLE);
    wire cntDone = (cnt_reg == 4'h0);

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cntDone ? 4'h0 : cnt_reg - 4'h1;
        case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = ST_ADDR;
                    cnt_next = ADDR_CYC - 4'h1; // R9
                end
            end
            ST_ADDR: begin
                if (cntDone) begin
                    state_next = ST_GAP; // R11
                    cnt_next = GAP_CYC - 4'h1;
                end
            end
            ST_GAP: begin
                if (cntDone) begin
                    state_next = ST_DATA;
                    cnt_next = STROBE_CYC - 4'h1; // R9
                end
            end
            ST_DATA: begin
                if (cntDone) begin
                    state_next = ST_HOLD;
                    cnt_next = HOLD_CYC - 4'h1;
                end
            end
            ST_HOLD: begin
                if (cntDone) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = 4'h0;
            end
        endcase
    end

    // Request values seen by the next pin state
    wire [ADDR_W-1:0] curAddr = take ? reqAddr : addr_reg;
    wire [DATA_W-1:0] curData = take ? reqWrData : wdata_reg;
    wire curWrite = take ? reqWrite : write_reg;
    wire [1:0] curArr = take ? chipSelectArrangement : arr_reg; // R10

    // Pin decode from the next state
    wire nAddrPh = (state_next == ST_ADDR) || (state_next == ST_GAP);
    wire nDataPh = (state_next == ST_DATA) || (state_next == ST_HOLD);
    wire nBusy = (state_next != ST_IDLE);
    wire nAle = (state_next == ST_ADDR); // R5 R11
    wire nOe = nAddrPh || (nDataPh && curWrite); // R3
    wire [DATA_W-1:0] nAd = nDataPh ? curData : curAddr[DATA_W-1:0]; // R3
    wire hiSel = curAddr[CS_SEL_BIT];
    wire nCs0 = nBusy && ((curArr == CSA_ONE_CS) || !hiSel); // R7
    wire nCs1 = nBusy && hiSel; // R7
    wire nLine30 = ((curArr == CSA_ALE_ONLY) || (curArr == CSA_ALE_TWO_CS))
        ? nAle : !nCs0; // R8
    wire nLine26 = (curArr == CSA_ALE_TWO_CS) ? !nCs0
        : curAddr[LINE26_BIT]; // R8
    wire nLine27 = ((curArr == CSA_TWO_CS) || (curArr == CSA_ALE_TWO_CS))
        ? !nCs1 : curAddr[CS_SEL_BIT]; // R8 R4
    wire nRdN = !((state_next == ST_DATA) && !curWrite); // R6
    wire nWrN = !((state_next == ST_DATA) && curWrite); // R6
    wire endAccess = (state_reg == ST_HOLD) && cntDone;
    // Synchronised value is two cycles old, still inside the strobe
    wire capRead = (state_reg == ST_DATA) && cntDone && !write_reg;

    // Read data pins pass a two-stage synchroniser
    data_line_sync u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .lineIn(adIn),
        .lineSync(adSync)
    );

    // Sequencer and request latch
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            addr_reg <= '0;
            wdata_reg <= '0;
            write_reg <= 1'b0;
            arr_reg <= CSA_ALE_ONLY;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= curAddr;
            wdata_reg <= curData;
            write_reg <= curWrite;
            arr_reg <= curArr;
        end
    end

    // Registered pins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            adOut <= '0;
            adOe <= '0;
            upperAddr <= '0;
            line26 <= 1'b0;
            line27 <= 1'b0;
            line30 <= 1'b0;
            rdStrobeN <= 1'b1;
            wrStrobeN <= 1'b1;
        end else begin
            adOut <= nAd;
            adOe <= {DATA_W{nOe}};
            upperAddr <= curAddr[UPPER_HI:UPPER_LO]; // R4
            line26 <= nLine26;
            line27 <= nLine27;
            line30 <= nLine30;
            rdStrobeN <= nRdN;
            wrStrobeN <= nWrN;
        end
    end

    // Request and answer side
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspRdData <= '0;
        end else begin
            reqReady <= modeOk && (state_next == ST_IDLE); // R1 R2
            rspValid <= endAccess;
            if (capRead) begin
                rspRdData <= adSync;
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    AST_MODE_GATE: // R1
    assert property (reqReady |->
        $past(interfaceMainMode) == MAIN_MODE_HOST_BYTE)
        else $error("ready raised outside byte host-bus mode");

    AST_SUBMODE_GATE: // R2
    assert property ($past(hostBusSubMode) != SUB_MODE_MUXED |-> !reqReady)
        else $error("ready raised outside muxed sub-mode");

    AST_ALE_CARRIES_ADDR: // R5
    assert property (state_reg == ST_ADDR |->
        adOe[0] && adOut == addr_reg[DATA_W-1:0])
        else $error("address not on lines while latch enable active");

    AST_ALE_BEFORE_STROBE: // R11
    assert property ($fell(rdStrobeN) || $fell(wrStrobeN) |->
        $past(state_reg) == ST_GAP && state_reg == ST_DATA)
        else $error("strobe asserted without a gap after latch enable");

    AST_STROBE_WIDTH: // R9
    assert property ($fell(rdStrobeN) |-> (!rdStrobeN) [*6] ##1 rdStrobeN)
        else $error("read strobe width wrong");

    AST_WRITE_DRIVES_DATA: // R3
    assert property (!wrStrobeN |-> adOe[0] && adOut == wdata_reg && rdStrobeN)
        else $error("write strobe without write data on lines");

    AST_READ_RELEASES: // R6
    assert property (!rdStrobeN |-> adOe == '0 && !write_reg && wrStrobeN)
        else $error("lines driven during read strobe");

    AST_ONE_SELECT: // R7
    assert property (arr_reg == CSA_ALE_TWO_CS && state_reg != ST_IDLE |->
        line26 != line27 && line26 == addr_reg[CS_SEL_BIT])
        else $error("not exactly the addressed chip select active");

    AST_ACCESS_ENDS: // R9
    assert property (take |-> ##[10:12] rspValid)
        else $error("access did not finish in time");

endmodule

`default_nettype wire

// ===== tb/host_bus_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_bus_periph_model (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Reset, active low
    input wire logic aleUsed, // Line 30 is latch enable
    input wire logic [7:0] adOut, // Port drive value
    input wire logic [7:0] adOe, // Port drive enable
    input wire logic rdStrobeN, // Read strobe, low
    input wire logic wrStrobeN, // Write strobe, low
    input wire logic line30, // Latch enable or select
    output logic [7:0] adIn, // Resolved line level
    output logic [7:0] latchAddr, // Latched low address
    output logic [7:0] wrData // Last byte written
);
    logic [7:0] driveReg;
    logic oePrevReg;

    // Port drives win; else peripheral or a churning released bus
    assign adIn = adOe[0] ? adOut : driveReg;

    // Latch, read answer and write capture
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            driveReg <= 8'h3C;
            oePrevReg <= 1'h0;
            latchAddr <= 8'h00;
            wrData <= 8'h00;
        end else begin
            oePrevReg <= adOe[0];
            if (aleUsed ? line30 : (adOe[0] && !oePrevReg)) begin
                latchAddr <= adOut;
            end
            driveReg <= !rdStrobeN ? (latchAddr ^ 8'hA5) : ~driveReg;
            if (!wrStrobeN) begin
                wrData <= adIn;
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/host_bus_byte_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module host_bus_byte_port_tb_top
    import host_bus_byte_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [1:0] c;
        logic [27:0] a;
        logic [7:0] d;
    } row_s;
    logic sys_clk, arst_n, reqValid, reqWrite, reqReady, rspValid;
    logic line26, line27, line30, rdStrobeN, wrStrobeN;
    logic [3:0] mainMode, subMode;
    logic [1:0] arr;
    logic [27:0] reqAddr;
    logic [7:0] reqWrData, rspRdData, adOut, adOe, adIn, latchAddr, wrData;
    logic [17:0] upperAddr;
    int errors, n_checks;
    wire aleUsed = (arr == CSA_ALE_ONLY) || (arr == CSA_ALE_TWO_CS);
    row_s rows [8] = '{
        '{1'h1, 2'h0, 28'h0000012, 8'h5A}, '{1'h0, 2'h0, 28'hFFFFF81, 8'h00},
        '{1'h1, 2'h1, 28'h8ABCD34, 8'hC3}, '{1'h0, 2'h1, 28'h4000007, 8'h00},
        '{1'h1, 2'h2, 28'h80000F0, 8'h01}, '{1'h0, 2'h2, 28'h0123456, 8'h00},
        '{1'h1, 2'h3, 28'h0FEDC99, 8'hFF}, '{1'h0, 2'h3, 28'hC00003C, 8'h00}};

    host_bus_byte_port i_host_bus_byte_port (.sys_clk(sys_clk),
        .arst_n(arst_n), .interfaceMainMode(mainMode),
        .hostBusSubMode(subMode), .chipSelectArrangement(arr),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWrData(reqWrData), .reqReady(reqReady), .rspValid(rspValid),
        .rspRdData(rspRdData), .adOut(adOut), .adOe(adOe), .adIn(adIn),
        .upperAddr(upperAddr), .line26(line26), .line27(line27),
        .line30(line30), .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN));
    host_bus_periph_model i_host_bus_periph_model (.sys_clk(sys_clk),
        .arst_n(arst_n), .aleUsed(aleUsed), .adOut(adOut), .adOe(adOe),
        .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .line30(line30),
        .adIn(adIn), .latchAddr(latchAddr), .wrData(wrData));

    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task tick;
        @(posedge sys_clk);
        #1;
    endtask

    // One access, walked phase by phase after the take edge
    task access(input row_s r);
        int n;
        logic [2:0] exp;
        reqValid = 1'h1;
        reqWrite = r.w;
        reqAddr = r.a;
        reqWrData = r.d;
        arr = r.c;
        n = 0;
        while (reqReady !== 1'h1 && n < 50) begin
            tick;
            n++;
        end
        tick;
        reqValid = 1'h0;
        tick;
        case (r.c)
            2'h0: exp = {1'h1, r.a[27], r.a[26]};
            2'h1: exp = {1'h0, r.a[27], r.a[26]};
            2'h2: exp = {r.a[27], ~r.a[27], r.a[26]};
            default: exp = {1'h1, ~r.a[27], r.a[27]};
        endcase
        chk({line30, line27, line26}, exp);
        chk({adOe, adOut}, {8'hFF, r.a[7:0]});
        chk(upperAddr, r.a[25:8]);
        // Gap: latch enable low, address still driven, no strobe yet
        tick;
        if (r.c == 2'h0 || r.c == 2'h3) chk(line30, 1'h0);
        chk({rdStrobeN, wrStrobeN, adOe}, 10'h3FF);
        tick;
        chk({rdStrobeN, wrStrobeN}, r.w ? 2'h2 : 2'h1);
        chk(adOe, r.w ? 8'hFF : 8'h00);
        // Last strobe cycle, then the hold cycle, then the answer
        repeat (5) tick;
        chk({rdStrobeN, wrStrobeN}, r.w ? 2'h2 : 2'h1);
        chk(rspValid, 1'h0);
        tick;
        chk({rspValid, rdStrobeN, wrStrobeN}, 3'h3);
        tick;
        chk(rspValid, 1'h1);
        if (r.w) chk({wrData, latchAddr}, {r.d, r.a[7:0]});
        else chk(rspRdData, r.a[7:0] ^ 8'hA5);
    endtask

    // Clock
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Watchdog
    initial begin
        #50000;
        errors++;
        report_and_stop;
    end

    // Main sequence
    initial begin
        arst_n = 1'h0;
        mainMode = MAIN_MODE_HOST_BYTE;
        subMode = SUB_MODE_MUXED;
        arr = CSA_ALE_ONLY;
        reqValid = 1'h0;
        reqWrite = 1'h0;
        reqAddr = 28'h0000000;
        reqWrData = 8'h00;
        errors = 0;
        n_checks = 0;
        repeat (20) tick;
        chk({reqReady, rspValid, rdStrobeN, wrStrobeN, line30, adOe},
            13'h0600);
        arst_n = 1'h1;
        repeat (2) tick;
        chk(reqReady, 1'h1);
        foreach (rows[i]) access(rows[i]);
        mainMode = 4'h1;
        repeat (2) tick;
        chk(reqReady, 1'h0);
        mainMode = MAIN_MODE_HOST_BYTE;
        subMode = 4'h1;
        repeat (2) tick;
        chk(reqReady, 1'h0);
        subMode = SUB_MODE_MUXED;
        repeat (2) tick;
        // Reset in mid-write drops strobes and drive at once
        reqValid = 1'h1;
        reqWrite = 1'h1;
        tick;
        reqValid = 1'h0;
        repeat (4) tick;
        chk({wrStrobeN, adOe}, 9'h0FF);
        arst_n = 1'h0;
        #1;
        chk({rdStrobeN, wrStrobeN, adOe, reqReady}, 11'h600);
        repeat (3) tick;
        arst_n = 1'h1;
        repeat (2) tick;
        access(rows[1]);
        report_and_stop;
    end
endmodule

`default_nettype wire
